// File: hw/dds_top.sv
// Drive status lines, serial config/status port, index/sector and NRZ data path
//
// Contract
// RQ1 - Command cable outputs are enabled only when drive select matches this drive.
// RQ2 - Drive Selected asserts only while select lines address this drive.
// RQ3 - Ready follows spindle speed; without Ready writes and seeks are blocked.
// RQ4 - Response is 16 bits MSB first plus one odd parity bit.
// RQ5 - Each response bit moves under req/ack; only after a request.
// RQ6 - A configuration request always gets a well formed answer.
// RQ7 - Modifier 0000 returns general flags, others the selected parameter word.
// RQ8 - Vendor unique status request returns one word holding the fault code.
// RQ9 - Status bits 15-12 are state; any bit 11-0 set raises Attention.
// RQ10 - Attention requests status; all writing is blocked while it is high.
// RQ11 - Attention stays high until the reset-attention control command.
// RQ12 - Control modifier 0000 clears Attention and status bits 11-0.
// RQ13 - Index idles high, falls once a turn; gated on command, ungated on data.
// RQ14 - One shared line carries sector or address mark found, per sectoring.
// RQ15 - Hard sectored: sector pulse per sector start; index marks sector zero.
// RQ16 - Soft sectored: address mark found during a search when mark ends.
// RQ17 - Command Complete is ungated and low while power-on recalibration runs.
// RQ18 - Command Complete drops on first command bit, low all through sequence.
// RQ19 - Write data sampled with Write Clock; read data aligned to Read Clock.
// RQ20 - Read data stays zero until the oscillator is locked and data valid.
// RQ21 - Reference clock without Read Gate, read clock once locked; glitch free.
// RQ22 - Controller echoes the reference clock back as Write Clock.
// RQ23 - Write Clock runs from before a write until its end.
// RQ24 - Response bit changes only between handshake steps.
`timescale 1ns/100ps

// ====================================================
// Two flip-flop synchroniser
module dds_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s1_r <= '0;
			s2_r <= '0;
		end else begin
			s1_r <= d;
			s2_r <= s1_r;
		end
	end
	assign q = s2_r;
endmodule

// ====================================================
// Top
module dds_top (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Interface pins in
	input wire dds_pkg::dds_pin_s pins,
	// Command cable out
	output dds_pkg::dds_cmd_out_s cmd_out,
	output logic cmd_oe_n,
	// Data cable out
	output dds_pkg::dds_data_out_s data_out,
	output logic rr_clk,
	output logic nrz_read_data,
	// Drive internals
	output logic wr_bit,
	output logic wr_bit_valid,
	output logic write_enable,
	output logic seek_start
);
	// ====================================================
	// Pin synchronisation
	dds_pkg::dds_pin_s ps;
	dds_pkg::dds_pin_s pp_r;
	dds_sync #(.W($bits(dds_pkg::dds_pin_s))) u_sync (
		.hclk(hclk),
		.hresetn(hresetn),
		.d(pins),
		.q(ps)
	);

	// ====================================================
	// Registers
	logic [15:0] ctrl_r, ctrl_nxt;
	logic [11:0] fault_r, fault_nxt;
	logic [15:0] vu_r, vu_nxt;
	logic [15:0] lastcmd_r, lastcmd_nxt;
	logic [15:0] cfg_r [16];
	logic [31:0] rdata_r, rdata_nxt;
	logic wr_pend_r, wr_pend_nxt;
	logic [7:0] waddr_r, waddr_nxt;
	logic ap_valid;
	logic [15:0] std_status;
	logic selected;
	logic ready;
	logic attn;
	logic hard_sec;
	logic clr_faults;

	assign ap_valid = hsel & htrans[1] & hready;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = rdata_r;
	assign ready = ctrl_r[dds_pkg::CTRL_SPIN_BIT]; // see RQ3
	assign hard_sec = ctrl_r[dds_pkg::CTRL_HARD_BIT];
	assign selected = (ps.drv_sel == ctrl_r[dds_pkg::CTRL_ADDR_LSB +: 3]); // see RQ2
	assign std_status = {ctrl_r[dds_pkg::CTRL_STATE_LSB +: 4], fault_r}; // see RQ9
	assign attn = |fault_r; // see RQ9, see RQ11

	always_comb begin
		ctrl_nxt = ctrl_r;
		fault_nxt = fault_r;
		vu_nxt = vu_r;
		rdata_nxt = rdata_r;
		wr_pend_nxt = ap_valid & hwrite;
		waddr_nxt = ap_valid ? haddr[7:0] : waddr_r;
		// Command clear first, bus set afterwards so a new fault wins
		if (clr_faults) begin
			fault_nxt = '0; // see RQ12
		end
		if (wr_pend_r) begin
			case (waddr_r)
				dds_pkg::ADDR_CTRL: begin
					ctrl_nxt = hwdata[15:0];
				end
				dds_pkg::ADDR_STATUS: begin
					fault_nxt = fault_nxt | hwdata[11:0];
				end
				dds_pkg::ADDR_VUFAULT: begin
					vu_nxt = hwdata[15:0];
				end
				default: begin
				end
			endcase
		end
		if (ap_valid && !hwrite) begin
			rdata_nxt = 32'h0000_0000;
			if (haddr[7:6] == dds_pkg::ADDR_CFG_BASE[7:6]) begin
				rdata_nxt = {16'h0000, cfg_r[haddr[5:2]]};
			end else begin
				case (haddr[7:0])
					dds_pkg::ADDR_CTRL: rdata_nxt = {16'h0000, ctrl_r};
					dds_pkg::ADDR_STATUS: rdata_nxt = {16'h0000, std_status};
					dds_pkg::ADDR_VUFAULT: rdata_nxt = {16'h0000, vu_r};
					dds_pkg::ADDR_LASTCMD: rdata_nxt = {16'h0000, lastcmd_r};
					dds_pkg::ADDR_LINK: rdata_nxt = {24'h000000, selected, attn,
						ps.plo_locked, ps.read_gate, ps.write_gate, ps.recal_busy,
						ps.xfer_req, ready};
					default: rdata_nxt = 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_r <= dds_pkg::CTRL_RST;
			fault_r <= dds_pkg::FAULT_RST;
			vu_r <= dds_pkg::VU_RST;
			rdata_r <= 32'h0000_0000;
			wr_pend_r <= 1'b0;
			waddr_r <= 8'h00;
		end else begin
			ctrl_r <= ctrl_nxt;
			fault_r <= fault_nxt;
			vu_r <= vu_nxt;
			rdata_r <= rdata_nxt;
			wr_pend_r <= wr_pend_nxt;
			waddr_r <= waddr_nxt;
		end
	end

	// Configuration word table, entry 0 is the general flag word
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < 16; i++) begin
				cfg_r[i] <= dds_pkg::CFG_RST;
			end
		end else if (wr_pend_r && waddr_r[7:6] == dds_pkg::ADDR_CFG_BASE[7:6]) begin
			cfg_r[waddr_r[5:2]] <= hwdata[15:0];
		end
	end

	// ====================================================
	// Serial command and response handshake
	dds_pkg::dds_hs_e hs_r, hs_nxt;
	logic [4:0] cnt_r, cnt_nxt;
	logic [16:0] sh_r, sh_nxt;
	logic ack_r, ack_nxt;
	logic busy_r, busy_nxt;
	logic clr_r, clr_nxt;
	logic seek_r, seek_nxt;
	logic [15:0] cmd_w;
	logic [15:0] resp_w;
	logic resp_go;

	assign cmd_w = sh_r[16:1];
	assign clr_faults = clr_r;

	// Pick the answer for a just received command
	always_comb begin
		resp_w = 16'h0000;
		resp_go = 1'b0;
		case (cmd_w[15:12])
			dds_pkg::OP_REQ_STATUS: begin
				resp_go = 1'b1;
				resp_w = (cmd_w[11:8] == dds_pkg::MOD_VENDOR) ? vu_r : std_status; // see RQ8
			end
			dds_pkg::OP_REQ_CONFIG: begin
				resp_go = 1'b1; // see RQ6
				resp_w = cfg_r[cmd_w[11:8]]; // see RQ7
			end
			default: begin
				resp_go = 1'b0;
			end
		endcase
	end

	always_comb begin
		hs_nxt = hs_r;
		cnt_nxt = cnt_r;
		sh_nxt = sh_r;
		ack_nxt = ack_r;
		busy_nxt = busy_r;
		clr_nxt = 1'b0;
		seek_nxt = 1'b0;
		lastcmd_nxt = lastcmd_r;
		case (hs_r)
			dds_pkg::HS_RX: begin
				if (ps.xfer_req && selected) begin
					sh_nxt = {sh_r[15:0], ps.cmd_data};
					ack_nxt = 1'b1;
					busy_nxt = 1'b1; // see RQ18
					hs_nxt = dds_pkg::HS_RXA;
				end
			end
			dds_pkg::HS_RXA: begin
				if (!ps.xfer_req) begin
					ack_nxt = 1'b0;
					if (cnt_r == dds_pkg::FRAME_LAST) begin
						cnt_nxt = 5'h00;
						lastcmd_nxt = cmd_w;
						if (cmd_w[15:12] == dds_pkg::OP_CONTROL &&
							cmd_w[11:8] == dds_pkg::MOD_ZERO) begin
							clr_nxt = 1'b1; // see RQ11, see RQ12
						end
						if (cmd_w[15:12] == dds_pkg::OP_SEEK) begin
							seek_nxt = ready; // see RQ3
						end
						if (resp_go) begin
							sh_nxt = {resp_w, ~^resp_w}; // see RQ4
							hs_nxt = dds_pkg::HS_TX;
						end else begin
							busy_nxt = 1'b0;
							hs_nxt = dds_pkg::HS_RX;
						end
					end else begin
						cnt_nxt = cnt_r + 5'h01;
						hs_nxt = dds_pkg::HS_RX;
					end
				end
			end
			dds_pkg::HS_TX: begin
				if (ps.xfer_req) begin
					ack_nxt = 1'b1; // see RQ5
					hs_nxt = dds_pkg::HS_TXA;
				end
			end
			dds_pkg::HS_TXA: begin
				if (!ps.xfer_req) begin
					ack_nxt = 1'b0;
					sh_nxt = {sh_r[15:0], 1'b0}; // see RQ24
					if (cnt_r == dds_pkg::FRAME_LAST) begin
						cnt_nxt = 5'h00;
						busy_nxt = 1'b0;
						hs_nxt = dds_pkg::HS_RX;
					end else begin
						cnt_nxt = cnt_r + 5'h01;
						hs_nxt = dds_pkg::HS_TX;
					end
				end
			end
			default: begin
				hs_nxt = dds_pkg::HS_RX;
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hs_r <= dds_pkg::HS_RX;
			cnt_r <= 5'h00;
			sh_r <= 17'h00000;
			ack_r <= 1'b0;
			busy_r <= 1'b0;
			clr_r <= 1'b0;
			seek_r <= 1'b0;
			lastcmd_r <= 16'h0000;
		end else begin
			hs_r <= hs_nxt;
			cnt_r <= cnt_nxt;
			sh_r <= sh_nxt;
			ack_r <= ack_nxt;
			busy_r <= busy_nxt;
			clr_r <= clr_nxt;
			seek_r <= seek_nxt;
			lastcmd_r <= lastcmd_nxt;
		end
	end

	// ====================================================
	// Status line outputs
	dds_pkg::dds_cmd_out_s co_r, co_nxt;
	dds_pkg::dds_data_out_s do_r, do_nxt;
	logic oe_n_r, oe_n_nxt;
	logic sa_line;
	logic in_resp;

	assign in_resp = (hs_r == dds_pkg::HS_TX) || (hs_r == dds_pkg::HS_TXA);

	always_comb begin
		// Hard sectored: sector pulses, index marks sector zero
		sa_line = ps.sector_raw; // see RQ14, see RQ15
		if (!hard_sec) begin
			// Soft sectored: mark end seen while searching
			sa_line = ps.am_detect & ps.am_enable & ~ps.read_gate & ~ps.write_gate; // see RQ16
		end
		co_nxt.attention = attn; // see RQ10
		co_nxt.ready = ready;
		co_nxt.index_n = ~ps.index_raw; // see RQ13
		co_nxt.sector_amf = sa_line;
		co_nxt.xfer_ack = ack_r;
		// Hold the bit until ack is seen low, so it never moves with ack
		co_nxt.cfg_data = co_r.xfer_ack ? co_r.cfg_data : (in_resp & sh_r[16]); // see RQ24
		oe_n_nxt = ~selected; // see RQ1
		do_nxt.drive_selected = selected; // see RQ2
		do_nxt.command_complete = ~busy_r & ~ps.recal_busy; // see RQ17, see RQ18
		do_nxt.index_n = ~ps.index_raw; // see RQ13
		do_nxt.sector_amf = sa_line;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			co_r <= '{attention: 1'b0, ready: 1'b0, index_n: 1'b1, sector_amf: 1'b0,
				xfer_ack: 1'b0, cfg_data: 1'b0};
			do_r <= '{drive_selected: 1'b0, command_complete: 1'b0, index_n: 1'b1,
				sector_amf: 1'b0};
			oe_n_r <= 1'b1;
		end else begin
			co_r <= co_nxt;
			do_r <= do_nxt;
			oe_n_r <= oe_n_nxt;
		end
	end

	assign cmd_out = co_r;
	assign data_out = do_r;
	assign cmd_oe_n = oe_n_r;

	// ====================================================
	// Read/reference clock and NRZ data
	logic [7:0] div_r, div_nxt;
	logic ref_r, ref_nxt;
	logic sel_rd_r, sel_rd_nxt;
	logic rr_r, rr_nxt;
	logic rd_r, rd_nxt;
	logic wbit_r, wbit_nxt;
	logic wval_r, wval_nxt;
	logic wen_r, wen_nxt;
	logic want_rd;
	logic src;

	assign want_rd = ps.read_gate & ps.plo_locked;

	always_comb begin
		div_nxt = div_r + 8'h01;
		ref_nxt = ref_r;
		if (div_r == 8'(dds_pkg::REF_HALF_CYC - 1)) begin
			div_nxt = 8'h00;
			ref_nxt = ~ref_r;
		end
		// Swap source only while output and new source are both low
		sel_rd_nxt = sel_rd_r;
		if (!rr_r && want_rd != sel_rd_r) begin
			if (want_rd ? !ps.plo_clk : !ref_r) begin
				sel_rd_nxt = want_rd; // see RQ21
			end
		end
		src = sel_rd_nxt ? ps.plo_clk : ref_r;
		rr_nxt = src;
		// Read data changes on falling output edge
		rd_nxt = rd_r;
		if (!sel_rd_r || !want_rd) begin
			rd_nxt = 1'b0; // see RQ20
		end else if (pp_r.plo_clk && !ps.plo_clk) begin
			rd_nxt = ps.read_bit; // see RQ19
		end
		// Write data taken on rising write clock
		wen_nxt = ps.write_gate & ready & ~attn; // see RQ3, see RQ10
		wval_nxt = 1'b0;
		wbit_nxt = wbit_r;
		if (ps.write_clk && !pp_r.write_clk && wen_r) begin
			wbit_nxt = ps.write_data; // see RQ19, see RQ22, see RQ23
			wval_nxt = 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_r <= 8'h00;
			ref_r <= 1'b0;
			sel_rd_r <= 1'b0;
			rr_r <= 1'b0;
			rd_r <= 1'b0;
			wbit_r <= 1'b0;
			wval_r <= 1'b0;
			wen_r <= 1'b0;
			pp_r <= '0;
		end else begin
			div_r <= div_nxt;
			ref_r <= ref_nxt;
			sel_rd_r <= sel_rd_nxt;
			rr_r <= rr_nxt;
			rd_r <= rd_nxt;
			wbit_r <= wbit_nxt;
			wval_r <= wval_nxt;
			wen_r <= wen_nxt;
			pp_r <= ps;
		end
	end

	assign rr_clk = rr_r;
	assign nrz_read_data = rd_r;
	assign wr_bit = wbit_r;
	assign wr_bit_valid = wval_r;
	assign write_enable = wen_r;
	assign seek_start = seek_r;
endmodule

// File: hw/dds_pkg.sv
// Constants, types and carriers for the drive status and NRZ data port
package dds_pkg;
	// ====================================================
	// Clock and timing
	localparam int CLK_MHZ = 200;
	localparam int REF_HALF_NS = 50;
	localparam int REF_HALF_CYC = (REF_HALF_NS * CLK_MHZ) / 1000;
	// ====================================================
	// Register byte offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_VUFAULT = 8'h08;
	localparam logic [7:0] ADDR_LASTCMD = 8'h0c;
	localparam logic [7:0] ADDR_LINK = 8'h10;
	localparam logic [7:0] ADDR_CFG_BASE = 8'h40;
	// ====================================================
	// Control register fields
	localparam int CTRL_SPIN_BIT = 0;
	localparam int CTRL_HARD_BIT = 1;
	localparam int CTRL_ADDR_LSB = 4;
	localparam int CTRL_STATE_LSB = 8;
	localparam logic [15:0] CTRL_RST = 16'h0000;
	localparam logic [11:0] FAULT_RST = 12'h000;
	localparam logic [15:0] VU_RST = 16'h0000;
	localparam logic [15:0] CFG_RST = 16'h0000;
	// ====================================================
	// Serial command frame
	localparam int WORD_BITS = 16;
	localparam logic [4:0] FRAME_LAST = 5'h10;
	localparam logic [3:0] OP_SEEK = 4'h0;
	localparam logic [3:0] OP_REQ_STATUS = 4'h2;
	localparam logic [3:0] OP_REQ_CONFIG = 4'h3;
	localparam logic [3:0] OP_CONTROL = 4'h5;
	localparam logic [3:0] MOD_ZERO = 4'h0;
	localparam logic [3:0] MOD_VENDOR = 4'h1;
	// ====================================================
	// Types
	typedef enum logic [1:0] {
		HS_RX = 2'b00,
		HS_RXA = 2'b01,
		HS_TX = 2'b10,
		HS_TXA = 2'b11
	} dds_hs_e;
	typedef struct packed {
		logic [2:0] drv_sel;
		logic xfer_req;
		logic cmd_data;
		logic index_raw;
		logic sector_raw;
		logic am_detect;
		logic am_enable;
		logic read_gate;
		logic write_gate;
		logic plo_clk;
		logic plo_locked;
		logic read_bit;
		logic write_clk;
		logic write_data;
		logic recal_busy;
	} dds_pin_s;
	typedef struct packed {
		logic attention;
		logic ready;
		logic index_n;
		logic sector_amf;
		logic xfer_ack;
		logic cfg_data;
	} dds_cmd_out_s;
	typedef struct packed {
		logic drive_selected;
		logic command_complete;
		logic index_n;
		logic sector_amf;
	} dds_data_out_s;
endpackage

// File: tb/dds_top_sva.sv
// Checker for the drive status port, bound to the top
`timescale 1ns/100ps
module dds_top_chk (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Watched ports
	input wire dds_pkg::dds_pin_s pins,
	input wire dds_pkg::dds_cmd_out_s cmd_out,
	input wire logic cmd_oe_n,
	input wire dds_pkg::dds_data_out_s data_out,
	input wire logic nrz_read_data,
	input wire logic rr_clk,
	input wire logic wr_bit_valid,
	input wire logic write_enable,
	input wire logic seek_start
);
	logic [2:0] up_r;
	logic [2:0] up_nxt;
	logic up;
	always_comb begin
		up_nxt = (up_r == 3'h7) ? up_r : up_r + 3'h1;
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			up_r <= 3'h0;
		end else begin
			up_r <= up_nxt;
		end
	end
	assign up = (up_r > 3'h4);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// ====================================================
	// Properties
	sel_gate_a: assert property (data_out.drive_selected == !cmd_oe_n)
		else $error("select gating mismatch");
	ready_block_a: assert property (!cmd_out.ready && $past(!cmd_out.ready) |->
		!write_enable && !seek_start) else $error("write or seek without ready");
	attn_block_a: assert property (cmd_out.attention && $past(cmd_out.attention) |->
		!write_enable) else $error("write during attention");
	index_pipe_a: assert property (up |-> data_out.index_n == !$past(pins.index_raw, 3))
		else $error("index pipe wrong");
	index_gate_a: assert property (up && !cmd_oe_n |->
		cmd_out.index_n == data_out.index_n && cmd_out.sector_amf == data_out.sector_amf)
		else $error("gated copy differs");
	ack_cause_a: assert property ($rose(cmd_out.xfer_ack) |->
		pins.xfer_req && $past(pins.xfer_req, 2)) else $error("ack without request");
	ack_drop_a: assert property ($fell(pins.xfer_req) |-> ##[1:6] !cmd_out.xfer_ack)
		else $error("ack stuck");
	resp_hold_a: assert property ($changed(cmd_out.cfg_data) |->
		!cmd_out.xfer_ack && !$past(cmd_out.xfer_ack)) else $error("bit moved in handshake");
	cc_drop_a: assert property (up && !cmd_oe_n && $rose(pins.xfer_req) &&
		data_out.command_complete |-> ##[1:6] !data_out.command_complete)
		else $error("complete not dropped");
	cc_busy_a: assert property (cmd_out.xfer_ack |-> !data_out.command_complete)
		else $error("complete during command");
	recal_cc_a: assert property (up && $past(pins.recal_busy, 3) &&
		$past(pins.recal_busy, 4) |-> !data_out.command_complete) else $error("complete in recal");
	nrz_zero_a: assert property (up && !$past(pins.plo_locked, 3) &&
		!$past(pins.plo_locked, 4) |-> !nrz_read_data) else $error("read data not zero");
	wr_blocked_a: assert property (!write_enable |=> !wr_bit_valid)
		else $error("write bit while blocked");
	seek_pulse_a: assert property (seek_start |=> !seek_start)
		else $error("seek pulse too long");
	rr_high_a: assert property ($rose(rr_clk) |-> rr_clk[*8])
		else $error("read clock pulse too short");
endmodule
bind dds_top dds_top_chk chk (.hclk(hclk), .hresetn(hresetn), .pins(pins), .cmd_out(cmd_out),
	.cmd_oe_n(cmd_oe_n), .data_out(data_out), .nrz_read_data(nrz_read_data),
	.rr_clk(rr_clk), .wr_bit_valid(wr_bit_valid),
	.write_enable(write_enable), .seek_start(seek_start));

// File: tb/dds_ctl_model.sv
// Disk controller model: serial handshake and write clock echo
`timescale 1ns/100ps
module dds_ctl_model (
	// Clock
	input wire logic hclk,
	// Drive side
	input wire logic xfer_ack,
	input wire logic cfg_data,
	input wire logic rr_clk,
	input wire logic wclk_on,
	// Controller side
	output logic xfer_req,
	output logic cmd_data,
	output logic write_clk
);
	logic [16:0] resp;
	event resp_done;
	initial begin
		xfer_req = 1'b0;
		cmd_data = 1'b0;
		write_clk = 1'b0;
	end
	// Echo of the read/reference clock rr_clk, only while wclk_on is set
	always @(posedge hclk) begin
		write_clk <= wclk_on ? rr_clk : 1'b0;
	end
	// One bit under request and acknowledge
	task bit_hs(input logic b, output logic s);
		cmd_data <= b;
		xfer_req <= 1'b1;
		do @(posedge hclk); while (xfer_ack !== 1'b1);
		s = cfg_data;
		xfer_req <= 1'b0;
		cmd_data <= ~b;
		do @(posedge hclk); while (xfer_ack !== 1'b0);
	endtask
	task xfer(input logic [15:0] c, input logic want);
		logic s;
		int i;
		for (i = 15; i >= 0; i--) bit_hs(c[i], s);
		bit_hs(~^c, s);
		if (want) begin
			for (i = 16; i >= 0; i--) begin
				bit_hs(1'b0, s);
				resp[i] = s;
			end
			->resp_done;
		end
	endtask
endmodule

// File: tb/testbench.sv
// Self-checking bench for the drive status port
`timescale 1ns/100ps
module testbench;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, cmd_oe_n, rr_clk, nrz_read_data;
	logic [1:0] htrans;
	logic [2:0] hsize, drv_sel;
	logic [31:0] haddr, hwdata, hrdata, f, r;
	logic idx, sec, amd, ame, rg, wg, plo, lock, rbit, wdat, recal, wclk_on, plo_run;
	logic req, cdat, wclk, rd_ph;
	logic [63:0] e;
	dds_pkg::dds_pin_s pins;
	dds_pkg::dds_cmd_out_s cmd_out;
	dds_pkg::dds_data_out_s data_out;
	int mismatches, comparisons, cyc, i;
	logic [63:0] exp_q[$];
	logic [16:0] rsp_q[$];

	always #2.5 hclk = ~hclk;
	always #80 if (plo_run) plo <= ~plo;
	assign pins = {drv_sel, req, cdat, idx, sec, amd, ame, rg, wg, plo, lock, rbit, wclk, wdat, recal};
	dds_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pins(pins), .cmd_out(cmd_out),
		.cmd_oe_n(cmd_oe_n), .data_out(data_out), .rr_clk(rr_clk), .nrz_read_data(nrz_read_data),
		.wr_bit(), .wr_bit_valid(), .write_enable(), .seek_start());
	dds_ctl_model ctl (.hclk(hclk), .xfer_ack(cmd_out.xfer_ack & ~cmd_oe_n),
		.cfg_data(cmd_out.cfg_data & ~cmd_oe_n), .rr_clk(rr_clk), .wclk_on(wclk_on),
		.xfer_req(req), .cmd_data(cdat), .write_clk(wclk));
	// ====================================================
	// Compares and verdict
	task cmp_reg(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
		comparisons++;
		if ((got & m) !== exp) begin
			mismatches++;
			$display("CHECK FAILED reg t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task cmp_rsp(input logic [16:0] got, input logic [16:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED rsp t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task give_verdict;
		$display("mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// Monitors
	always @(posedge hclk) begin
		if (rd_ph && hreadyout === 1'b1) begin
			e = exp_q.pop_front();
			cmp_reg(hrdata, e[31:0], e[63:32]);
			cmp_reg({31'h0, hresp}, 32'h0, 32'h1);
		end
		if (hreadyout === 1'b1) rd_ph = hsel && htrans[1] && !hwrite;
	end
	always begin
		@(ctl.resp_done);
		cmp_rsp(ctl.resp, rsp_q.pop_front());
	end
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			mismatches = mismatches + 1;
			give_verdict;
		end
	end
	// ====================================================
	// Drivers
	task ahb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'b10;
		if (!w) exp_q.push_back({m, d & m});
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= w ? d : 32'h0;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		@(posedge hclk);
	endtask
	task cmd(input logic [3:0] op, input logic [3:0] md, input logic [15:0] w);
		if (op == dds_pkg::OP_REQ_STATUS || op == dds_pkg::OP_REQ_CONFIG) rsp_q.push_back({w, ~^w});
		ctl.xfer({op, md, 8'h5a}, op == dds_pkg::OP_REQ_STATUS || op == dds_pkg::OP_REQ_CONFIG);
		repeat (4) @(posedge hclk);
	endtask
	initial begin
		hclk = 1'b0;
		hresetn = 1'b0;
		{hsel, hwrite, htrans, haddr, hwdata, drv_sel} = '0;
		hsize = 3'b010;
		{idx, sec, amd, ame, rg, wg, plo, lock, rbit, wdat, recal, wclk_on, plo_run} = '0;
		{mismatches, comparisons, cyc, rd_ph} = '0;
		void'($urandom(32'hd7e0));
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		ahb(1'b0, dds_pkg::ADDR_CTRL, {16'h0, dds_pkg::CTRL_RST}, '1);
		ahb(1'b0, 8'h20, 32'h0, '1);
		ahb(1'b1, dds_pkg::ADDR_CTRL, 32'h0a13, '0);
		drv_sel <= 3'h1;
		ahb(1'b0, dds_pkg::ADDR_CTRL, 32'h0a13, '1);
		ahb(1'b0, dds_pkg::ADDR_LINK, 32'h81, 32'hc1);
		$display("test registers done");
		f = ($urandom & 32'hfff) | 32'h1;
		ahb(1'b1, dds_pkg::ADDR_STATUS, f, '0);
		ahb(1'b0, dds_pkg::ADDR_STATUS, {16'h0, 4'ha, f[11:0]}, '1);
		ahb(1'b0, dds_pkg::ADDR_LINK, 32'h40, 32'h40);
		cmd(dds_pkg::OP_REQ_STATUS, dds_pkg::MOD_ZERO, {4'ha, f[11:0]});
		r = $urandom & 32'hffff;
		ahb(1'b1, dds_pkg::ADDR_VUFAULT, r, '0);
		cmd(dds_pkg::OP_REQ_STATUS, dds_pkg::MOD_VENDOR, r[15:0]);
		cmd(dds_pkg::OP_CONTROL, dds_pkg::MOD_ZERO, 16'h0);
		ahb(1'b0, dds_pkg::ADDR_STATUS, 32'ha000, '1);
		ahb(1'b0, dds_pkg::ADDR_LINK, 32'h0, 32'h40);
		cmd(dds_pkg::OP_SEEK, 4'h3, 16'h0);
		ahb(1'b0, dds_pkg::ADDR_LASTCMD, 32'h035a, '1);
		$display("test attention done");
		for (i = 0; i < 16; i++) begin
			r = $urandom & 32'hffff;
			ahb(1'b1, dds_pkg::ADDR_CFG_BASE + {2'b00, i[3:0], 2'b00}, r, '0);
			cmd(dds_pkg::OP_REQ_CONFIG, i[3:0], r[15:0]);
		end
		drv_sel <= 3'h2;
		repeat (3) @(posedge hclk);
		ahb(1'b0, dds_pkg::ADDR_LINK, 32'h0, 32'h80);
		drv_sel <= 3'h1;
		$display("test config done");
		recal <= 1'b1;
		wclk_on <= 1'b1;
		plo_run <= 1'b1;
		repeat (30) @(posedge hclk);
		recal <= 1'b0;
		for (i = 0; i < 600; i++) begin
			@(posedge hclk);
			{idx, sec, amd, ame, rbit, wdat} <= 6'($urandom);
			if (i % 100 == 0) {rg, lock, wg} <= 3'($urandom);
		end
		{rg, lock, wg, plo_run} <= '0;
		$display("test pins done");
		give_verdict;
	end
endmodule
